// *** rtl/scp_clk_src.sv ***
/*
 * PWM clock source: turns the selected source into a one-cycle tick.
 * Assumes low_speed_rc_clock is asynchronous and far slower than clk.
 */
`timescale 1ns/1ps
module scp_clk_src
    import scp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire scp_clk_sel_t clk_sel,
    input wire logic low_speed_rc_clock,
    output logic tick
);

    logic [1:0] div_q;
    logic rc_meta_q;
    logic rc_sync_q;
    logic rc_prev_q;

    // ==========================================================
    // Divide by four
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 2'h0;
        end else if (!run) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    // ==========================================================
    // Slow RC clock: two-stage synchroniser, then rising-edge detect
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rc_meta_q <= 1'b0;
            rc_sync_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_meta_q <= low_speed_rc_clock;
            rc_sync_q <= rc_meta_q;
            rc_prev_q <= rc_sync_q;
        end
    end

    always_comb begin
        unique case (clk_sel)
            SCP_CLK_DIV4: tick = run && (div_q == SCP_DIV4_LAST);
            SCP_CLK_LIRC: tick = run && rc_sync_q && !rc_prev_q;
            default: tick = run;
        endcase
    end

endmodule // scp_clk_src

// *** rtl/scp_duty_cmp.sv ***
/*
 * Sub-cycle comparator: decides whether the output is high for the
 * current position in the 256-period PWM cycle.
 * Assumes the duty value is held stable for a whole PWM cycle.
 */
`timescale 1ns/1ps
module scp_duty_cmp
    import scp_pkg::*;
(
    input wire logic [7:0] cycle_cnt,
    input wire logic [7:0] duty,
    input wire scp_mode_t mode,
    output logic level_hi
);

    logic [7:0] hc_62;
    logic [7:0] hc_71;

    always_comb begin
        hc_62 = scp_high_count({1'b0, duty[7:2]}, duty[1:0], cycle_cnt[7:6]);
        hc_71 = scp_high_count(duty[7:1], {1'b0, duty[0]}, {1'b0, cycle_cnt[7]});
        if (mode == SCP_MODE_71) begin
            level_hi = {1'b0, cycle_cnt[6:0]} < hc_71;
        end else begin
            level_hi = {2'b00, cycle_cnt[5:0]} < hc_62;
        end
    end

endmodule // scp_duty_cmp

// *** rtl/scp_pkg.sv ***
/*
 * Shared constants, types and helpers for the split-cycle PWM generator.
 * Assumes a single 25 MHz system clock and an APB register bus with
 * 32-bit data and 12-bit byte addresses.
 */
package scp_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] SCP_OFS_DUTY = 12'h000;
    localparam logic [11:0] SCP_OFS_CTRL = 12'h004;
    localparam logic [11:0] SCP_OFS_PORT = 12'h008;
    localparam logic [11:0] SCP_OFS_STAT = 12'h00c;

    // ==========================================================
    // Field positions
    localparam int unsigned SCP_CTRL_FN_BIT = 0;
    localparam int unsigned SCP_CTRL_MODE_BIT = 1;
    localparam int unsigned SCP_CTRL_CLK_LSB = 2;
    localparam int unsigned SCP_PORT_DATA_BIT = 0;
    localparam int unsigned SCP_PORT_DIR_BIT = 1;
    localparam int unsigned SCP_PORT_PULL_BIT = 2;
    localparam int unsigned SCP_STAT_LVL_BIT = 0;
    localparam int unsigned SCP_STAT_PIN_BIT = 1;
    localparam int unsigned SCP_STAT_CNT_LSB = 8;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SCP_DUTY_RST = 8'h00;
    localparam logic [3:0] SCP_CTRL_RST = 4'h0;
    localparam logic [2:0] SCP_PORT_RST = 3'h2;

    // ==========================================================
    // Timing counts, in PWM clock periods or system clocks
    localparam logic [7:0] SCP_CYCLE_LAST = 8'hff;
    localparam logic [6:0] SCP_SUB71_LAST = 7'h7f;
    localparam logic [5:0] SCP_SUB62_LAST = 6'h3f;
    localparam logic [1:0] SCP_DIV4_LAST = 2'h3;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SCP_CLK_SYS = 2'b00,
        SCP_CLK_DIV4 = 2'b01,
        SCP_CLK_LIRC = 2'b10
    } scp_clk_sel_t;

    typedef enum logic {
        SCP_MODE_62 = 1'b0,
        SCP_MODE_71 = 1'b1
    } scp_mode_t;

    typedef struct packed {
        scp_clk_sel_t clk_sel;
        scp_mode_t mode;
        logic fn_en;
    } scp_cfg_t;

    typedef struct packed {
        logic pull_en;
        logic dir_in;
        logic data;
    } scp_port_t;

    // High time of one sub-cycle: coarse count, plus one while the
    // sub-cycle index is below the fine spread count.
    function automatic logic [7:0] scp_high_count(input logic [6:0] coarse,
                                                  input logic [1:0] fine,
                                                  input logic [1:0] idx);
        return {1'b0, coarse} + ((idx < fine) ? 8'h01 : 8'h00);
    endfunction

endpackage

// *** rtl/scp_pwm_top.sv ***
/*
 * Split-cycle 8-bit PWM generator with APB registers and a shared pin.
 * Assumes a 25 MHz clk, an APB master on the same clock, and an
 * external pad that resolves the pin from output and output enable.
 */
`timescale 1ns/1ps
module scp_pwm_top
    import scp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_speed_rc_clock,
    input wire logic shared_output_pin_i,
    output logic shared_output_pin_o,
    output logic shared_output_pin_oe,
    output logic pull_high_en
);

    // ==========================================================
    // Declarations
    logic [7:0] duty_cycle_value_q;
    scp_cfg_t system_control_reg_q;
    scp_port_t port_q;
    logic [7:0] duty_shadow_q;
    logic [7:0] cycle_cnt_q;
    logic pwm_q;
    logic pin_o_q;
    logic pin_oe_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pwm_tick;
    logic level_hi;
    logic setup;
    logic wr_acc;
    logic hit_duty;
    logic hit_ctrl;
    logic hit_port;
    logic hit_stat;
    logic [31:0] rd_mux;
    logic pin_o_d;

    // ==========================================================
    // APB decode
    always_comb begin
        hit_duty = (paddr == SCP_OFS_DUTY);
        hit_ctrl = (paddr == SCP_OFS_CTRL);
        hit_port = (paddr == SCP_OFS_PORT);
        hit_stat = (paddr == SCP_OFS_STAT);
        setup = psel && !penable;
        wr_acc = psel && penable && pwrite;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_duty) begin
            rd_mux[7:0] = duty_cycle_value_q;
        end
        if (hit_ctrl) begin
            rd_mux[3:0] = system_control_reg_q;
        end
        if (hit_port) begin
            rd_mux[2:0] = port_q;
        end
        if (hit_stat) begin
            rd_mux[SCP_STAT_LVL_BIT] = pwm_q;
            rd_mux[SCP_STAT_PIN_BIT] = pin_sync_q;
            rd_mux[SCP_STAT_CNT_LSB +: 8] = cycle_cnt_q;
        end
    end

    // Read data and error are captured in the setup phase so that
    // the access phase presents them from flip-flops with no wait.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !(hit_duty || hit_ctrl || hit_port || (hit_stat && !pwrite));
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = 1'b1;

    // ==========================================================
    // Software registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            duty_cycle_value_q <= SCP_DUTY_RST;
        end else if (wr_acc && hit_duty) begin
            duty_cycle_value_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            system_control_reg_q <= SCP_CTRL_RST;
        end else if (wr_acc && hit_ctrl) begin
            system_control_reg_q.fn_en <= pwdata[SCP_CTRL_FN_BIT];
            system_control_reg_q.mode <= scp_mode_t'(pwdata[SCP_CTRL_MODE_BIT]);
            // The unused select code falls back to the system clock
            system_control_reg_q.clk_sel <= scp_clk_sel_t'(pwdata[SCP_CTRL_CLK_LSB +: 2]);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_q <= SCP_PORT_RST;
        end else if (wr_acc && hit_port) begin
            port_q.data <= pwdata[SCP_PORT_DATA_BIT];
            port_q.dir_in <= pwdata[SCP_PORT_DIR_BIT];
            port_q.pull_en <= pwdata[SCP_PORT_PULL_BIT];
        end
    end

    // ==========================================================
    // PWM clock and cycle counter
    scp_clk_src u_clk_src (
        .clk(clk),
        .reset_n(reset_n),
        .run(system_control_reg_q.fn_en),
        .clk_sel(system_control_reg_q.clk_sel),
        .low_speed_rc_clock(low_speed_rc_clock),
        .tick(pwm_tick)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cycle_cnt_q <= 8'h00;
        end else if (!system_control_reg_q.fn_en) begin
            cycle_cnt_q <= 8'h00;
        end else if (pwm_tick) begin
            cycle_cnt_q <= cycle_cnt_q + 8'h01;
        end
    end

    // The duty value takes effect only at a cycle boundary or while fn_en is off, so a write
    // never produces a torn sub-cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            duty_shadow_q <= SCP_DUTY_RST;
        end else if (!system_control_reg_q.fn_en) begin
            duty_shadow_q <= duty_cycle_value_q;
        end else if (pwm_tick && cycle_cnt_q == SCP_CYCLE_LAST) begin
            duty_shadow_q <= duty_cycle_value_q;
        end
    end

    // ==========================================================
    // Waveform
    scp_duty_cmp u_duty_cmp (
        .cycle_cnt(cycle_cnt_q),
        .duty(duty_shadow_q),
        .mode(system_control_reg_q.mode),
        .level_hi(level_hi)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_q <= 1'b0;
        end else if (!system_control_reg_q.fn_en) begin
            pwm_q <= 1'b0;
        end else if (pwm_tick) begin
            pwm_q <= level_hi;
        end
    end

    // ==========================================================
    // Shared pin
    always_comb begin
        if (system_control_reg_q.fn_en) begin
            pin_o_d = port_q.data && pwm_q;
        end else begin
            pin_o_d = port_q.data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_o_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_o_q <= pin_o_d;
            pin_oe_q <= !port_q.dir_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= shared_output_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    assign shared_output_pin_o = pin_o_q;
    assign shared_output_pin_oe = pin_oe_q;
    // Pull-high stays usable whether or not PWM is selected
    assign pull_high_en = port_q.pull_en && port_q.dir_in;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_cycle_wrap;
        system_control_reg_q.fn_en && pwm_tick && cycle_cnt_q == SCP_CYCLE_LAST
            && $stable(system_control_reg_q.fn_en) |=> cycle_cnt_q == 8'h00;
    endproperty
    a_cycle_wrap: assert property (p_cycle_wrap) else $error("cycle did not wrap after 256");

    property p_div4_spacing;
        system_control_reg_q.fn_en && system_control_reg_q.clk_sel == SCP_CLK_DIV4
            && pwm_tick |=> !pwm_tick [*3];
    endproperty
    a_div4_spacing: assert property (p_div4_spacing) else $error("divide-by-4 tick too early");

    property p_off_quiet;
        !system_control_reg_q.fn_en |=> !pwm_q && cycle_cnt_q == 8'h00;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("PWM runs while switched off");

    property p_62_high;
        system_control_reg_q.fn_en && pwm_tick && system_control_reg_q.mode == SCP_MODE_62
            && cycle_cnt_q[5:0] < duty_shadow_q[7:2] |=> pwm_q;
    endproperty
    a_62_high: assert property (p_62_high) else $error("6+2 coarse part not high");

    property p_62_low;
        system_control_reg_q.fn_en && pwm_tick && system_control_reg_q.mode == SCP_MODE_62
            && {2'b00, cycle_cnt_q[5:0]} > {2'b00, duty_shadow_q[7:2]} |=> !pwm_q;
    endproperty
    a_62_low: assert property (p_62_low) else $error("6+2 output high past its count");

    property p_62_spread;
        system_control_reg_q.fn_en && pwm_tick && system_control_reg_q.mode == SCP_MODE_62
            && cycle_cnt_q[5:0] == duty_shadow_q[7:2]
            |=> pwm_q == ($past(cycle_cnt_q[7:6]) < $past(duty_shadow_q[1:0]));
    endproperty
    a_62_spread: assert property (p_62_spread) else $error("6+2 fine spread wrong");

    property p_71_high;
        system_control_reg_q.fn_en && pwm_tick && system_control_reg_q.mode == SCP_MODE_71
            && cycle_cnt_q[6:0] < duty_shadow_q[7:1] |=> pwm_q;
    endproperty
    a_71_high: assert property (p_71_high) else $error("7+1 coarse part not high");

    property p_71_spread;
        system_control_reg_q.fn_en && pwm_tick && system_control_reg_q.mode == SCP_MODE_71
            && cycle_cnt_q[6:0] == duty_shadow_q[7:1]
            |=> pwm_q == (!$past(cycle_cnt_q[7]) && $past(duty_shadow_q[0]));
    endproperty
    a_71_spread: assert property (p_71_spread) else $error("7+1 fine spread wrong");

    property p_shadow_load;
        system_control_reg_q.fn_en && pwm_tick && cycle_cnt_q == SCP_CYCLE_LAST
            |=> duty_shadow_q == $past(duty_cycle_value_q);
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("duty not taken at cycle end");

    property p_pin_forced_low;
        system_control_reg_q.fn_en && !port_q.data |=> !shared_output_pin_o;
    endproperty
    a_pin_forced_low: assert property (p_pin_forced_low) else $error("pin not forced low");

    property p_pin_follows;
        system_control_reg_q.fn_en && port_q.data && !port_q.dir_in
            |=> shared_output_pin_o == $past(pwm_q) && shared_output_pin_oe;
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("pin does not follow PWM");

    property p_pin_input;
        port_q.dir_in |=> !shared_output_pin_oe;
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("pin driven while an input");

    property p_apb_err;
        psel && !penable && !(hit_duty || hit_ctrl || hit_port || hit_stat) |=> pslverr;
    endproperty
    a_apb_err: assert property (p_apb_err) else $error("unmapped address not refused");

endmodule // scp_pwm_top

// *** verif/scp_pin_load.sv ***
/*
 * External load on the shared output pin: resolves the pad level.
 * Assumes the bench may drive the pin itself while the block does not.
 */
`timescale 1ns/1ps
module scp_pin_load (
    input wire logic clk,
    input wire logic shared_output_pin_o,
    input wire logic shared_output_pin_oe,
    input wire logic pull_high_en,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pad
);
    // ==========================================================
    // Pad resolution
    // A floating pad wanders so a stale value can never pass for a read
    logic float_q = 1'b0;

    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        if (shared_output_pin_oe) begin
            pad = shared_output_pin_o;
        end else if (ext_en) begin
            pad = ext_val;
        end else if (pull_high_en) begin
            pad = 1'b1;
        end else begin
            pad = float_q;
        end
    end
endmodule // scp_pin_load

// *** verif/scp_pwm_top_tb_top.sv ***
/*
 * Self-checking bench for the split-cycle PWM generator.
 * Assumes the design answers APB with zero wait states or more.
 */
`timescale 1ns/1ps
module scp_pwm_top_tb_top;
    import scp_pkg::*;

    typedef struct {
        logic mode;
        logic [7:0] duty;
        logic [1:0] sel;
        int nsub;
        int hmax;
        int hmin;
    } scp_row_t;

    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, low_speed_rc_clock = 1'b0, shared_output_pin_i;
    logic shared_output_pin_o, shared_output_pin_oe, pull_high_en, er;
    logic ext_en = 1'b0, ext_val = 1'b0;
    int err_count = 0, tests_run = 0, n, s, mx, mn, dv, h;
    // The last row uses the spare select code, which runs as the system clock
    scp_row_t rows[8] = '{
        '{1'b0, 8'h45, 2'd0, 4, 18, 17}, '{1'b0, 8'h07, 2'd1, 4, 2, 1},
        '{1'b0, 8'h04, 2'd2, 4, 1, 1}, '{1'b0, 8'h02, 2'd0, 2, 1, 1},
        '{1'b1, 8'h64, 2'd0, 2, 50, 50}, '{1'b1, 8'hc9, 2'd1, 2, 101, 100},
        '{1'b1, 8'h01, 2'd0, 1, 1, 1}, '{1'b0, 8'h81, 2'd3, 4, 33, 32}};

    scp_pwm_top uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_speed_rc_clock(low_speed_rc_clock),
        .shared_output_pin_i(shared_output_pin_i),
        .shared_output_pin_o(shared_output_pin_o),
        .shared_output_pin_oe(shared_output_pin_oe), .pull_high_en(pull_high_en));
    scp_pin_load load (.clk(clk), .shared_output_pin_o(shared_output_pin_o),
        .shared_output_pin_oe(shared_output_pin_oe), .pull_high_en(pull_high_en),
        .ext_en(ext_en), .ext_val(ext_val), .pad(shared_output_pin_i));

    // ==========================================================
    // Clocks and watchdog
    initial begin
        forever #20 clk = ~clk;
    end
    // Slow RC clock: 16 system clocks a period, phase unrelated
    initial begin
        #7;
        forever #320 low_speed_rc_clock = ~low_speed_rc_clock;
    end
    // The tests need about 9,500 clocks; 40,000 leaves a wide margin
    initial begin
        #1600000;
        err_count++;
        end_of_test();
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Answer is looked at where it has settled; it stands until the next rising edge
        @(negedge clk);
        while (pready !== 1'b1) begin
            @(negedge clk);
        end
        rd = prdata;
        er = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // High samples of the pin over cyc clocks
    task automatic count_high(input int cyc);
        h = 0;
        // The pin register lags the last register write by one clock
        @(posedge clk);
        repeat (cyc) begin
            @(negedge clk);
            if (shared_output_pin_o === 1'b1) h++;
        end
    endtask

    // Runs of high over one full PWM cycle, starting at a falling edge
    task automatic measure(input int per);
        int run, k;
        logic prev;
        n = 0;
        s = 0;
        mx = 0;
        mn = 1 << 20;
        run = 0;
        k = 0;
        prev = 1'b0;
        while (!(prev === 1'b1 && shared_output_pin_o === 1'b0) && k < 20000) begin
            prev = shared_output_pin_o;
            @(negedge clk);
            k++;
        end
        if (k >= 20000) begin
            err_count++;
            $display("[FAIL] %0t ns: no falling edge on the pin", $time);
        end
        repeat (per) begin
            @(negedge clk);
            if (shared_output_pin_o === 1'b1) begin
                run++;
            end else if (run != 0) begin
                n++;
                s += run;
                if (run > mx) mx = run;
                if (run < mn) mn = run;
                run = 0;
            end
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        check({shared_output_pin_o, shared_output_pin_oe, pull_high_en}, 3'b000);
        reset_n <= 1'b1;
        apb(1'b0, SCP_OFS_DUTY, 32'h0);
        check(rd, {24'h0, SCP_DUTY_RST});
        apb(1'b0, SCP_OFS_CTRL, 32'h0);
        check(rd, {28'h0, SCP_CTRL_RST});
        apb(1'b0, SCP_OFS_PORT, 32'h0);
        check(rd, {29'h0, SCP_PORT_RST});
        $display("Reset values done");

        foreach (rows[i]) begin
            dv = (rows[i].sel == 2'd1) ? 4 : (rows[i].sel == 2'd2) ? 16 : 1;
            apb(1'b1, SCP_OFS_CTRL, 32'h0);
            apb(1'b1, SCP_OFS_DUTY, {24'h0, rows[i].duty});
            apb(1'b1, SCP_OFS_PORT, 32'h1);
            apb(1'b1, SCP_OFS_CTRL, {28'h0, rows[i].sel, rows[i].mode, 1'b1});
            measure(256 * dv);
            check(s, rows[i].duty * dv);
            check(n, rows[i].nsub);
            check(mx, rows[i].hmax * dv);
            check(mn, rows[i].hmin * dv);
            check(shared_output_pin_oe, 1'b1);
            $display("Row %0d done", i);
        end

        apb(1'b1, SCP_OFS_PORT, 32'h0);
        count_high(600);
        check(h, 0);
        apb(1'b1, SCP_OFS_CTRL, 32'h0);
        apb(1'b1, SCP_OFS_DUTY, 32'h0);
        apb(1'b1, SCP_OFS_PORT, 32'h1);
        apb(1'b1, SCP_OFS_CTRL, 32'h1);
        count_high(600);
        check(h, 0);
        apb(1'b1, SCP_OFS_PORT, 32'h6);
        repeat (4) @(posedge clk);
        check({shared_output_pin_oe, pull_high_en}, 2'b01);
        apb(1'b0, SCP_OFS_STAT, 32'h0);
        check(rd[SCP_STAT_PIN_BIT], 1'b1);
        ext_en <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, SCP_OFS_STAT, 32'h0);
        check(rd[SCP_STAT_PIN_BIT], 1'b0);
        $display("Pin control done");

        apb(1'b1, SCP_OFS_STAT, 32'hffff);
        check(er, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, SCP_OFS_PORT, 32'h0);
        check(rd, {29'h0, SCP_PORT_RST});
        $display("Refusal and reset done");
        end_of_test();
    end
endmodule // scp_pwm_top_tb_top
